// ===== src/pad_pkg.sv
// Package for the physical address decoder: field layout, spaces and carriers.
package pad_pkg;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int PAD_ADDR_W = 64;
   localparam int PAD_PHYS_W = 50;
   localparam int PAD_NODE_HI = 49;
   localparam int PAD_NODE_LO = 38;
   localparam int PAD_NODE_W = 12;
   localparam int PAD_TYPE_BIT = 38;
   localparam int PAD_SEL_HI = 37;
   localparam int PAD_SEL_LO = 36;
   localparam int PAD_HALF_BIT = 35;
   localparam int PAD_OFS_W = 36;
   localparam int PAD_MAX_PROC_NODES = 256;

   // ----------------------------------------
   // Space codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      PAD_SP_LOCAL_GLOBAL = 2'h0,
      PAD_SP_GET = 2'h1,
      PAD_SP_ATOMIC = 2'h2,
      PAD_SP_CACHEABLE = 2'h3
   } pad_space_e;

   // Request as issued by a processor
   typedef struct packed {
      logic valid;
      logic [PAD_ADDR_W-1:0] addr;
   } pad_req_s;

   // Decoded request towards the node hubs
   typedef struct packed {
      logic valid;
      logic [PAD_NODE_W-1:0] node_id;
      logic proc_node;
      pad_space_e space_selector_bits;
      logic local_space;
      logic mapped_register_space;
      logic get_space;
      logic atomic_op_space;
      logic mem_req;
      logic pio_target;
      logic [PAD_OFS_W-1:0] offset;
      logic reserved_err;
      logic bit49_err;
      logic odd_hub_err;
   } pad_dec_s;

   localparam pad_dec_s PAD_DEC_RESET = '0;
endpackage

// ===== src/pad_decoder.sv
// Physical address decoder: splits a request address into routing fields.
//
// Functional notes
// - Only bits below 50 carry meaning
// - Node identifier from bits 49:38, 256 nodes
// - Bit 38 zero means processor node
// - Bit 49 always zero; a set bit 49 only raises bit49_err and is still routed
// - Node identifier selects 256 GB hub region
// - Bits 37:36 pick one of four spaces
// - Bits 35:0 are byte offset
// - Space 00 halved by bit 35
// - Bits 37:35 000 go local resource
// - Bits 37:35 001 go global registers
// - Global registers reachable from any node
// - Programmed I/O decoded in global registers
// - Hub node identifiers are even; an odd one only raises odd_hub_err and is still routed
// - Space 11 issues memory request
`timescale 1ns/100ps
module pad_decoder (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Request from processor side
   input wire pad_pkg::pad_req_s req,
   // Decoded request to hub side
   output pad_pkg::pad_dec_s dec
);
   import pad_pkg::*;

   typedef struct packed {
      pad_dec_s dec;
   } pad_state_s;

   pad_state_s state;
   pad_state_s next_state;

   // ----------------------------------------
   // Field extraction
   // ----------------------------------------
   // Space 00 test plus half choice; shared by both halves so the
   // Selector compare lives in one place
   function automatic logic pad_zero_half(input logic [PAD_ADDR_W-1:0] a, input logic upper);
      return (a[PAD_SEL_HI:PAD_SEL_LO] == PAD_SP_LOCAL_GLOBAL) && (a[PAD_HALF_BIT] == upper);
   endfunction

   function automatic pad_dec_s pad_decode(input logic [PAD_ADDR_W-1:0] a);
      pad_dec_s d;
      d = PAD_DEC_RESET;
      d.valid = 1'h1;
      d.node_id = a[PAD_NODE_HI:PAD_NODE_LO];
      d.proc_node = ~a[PAD_TYPE_BIT];
      d.space_selector_bits = pad_space_e'(a[PAD_SEL_HI:PAD_SEL_LO]);
      d.offset = a[PAD_OFS_W-1:0];
      // Halves of space 00 chosen by bit 35
      d.local_space = pad_zero_half(a, 1'h0);
      // No source check: any node may reach another's registers
      d.mapped_register_space = pad_zero_half(a, 1'h1);
      d.pio_target = d.mapped_register_space;
      d.get_space = (d.space_selector_bits == PAD_SP_GET);
      d.atomic_op_space = (d.space_selector_bits == PAD_SP_ATOMIC);
      d.mem_req = (d.space_selector_bits == PAD_SP_CACHEABLE);
      // Flags only; upper bits never steer routing
      d.reserved_err = |a[PAD_ADDR_W-1:PAD_PHYS_W];
      d.bit49_err = a[PAD_NODE_HI];
      d.odd_hub_err = a[PAD_NODE_LO];
      return d;
   endfunction

   // ----------------------------------------
   // Next state and register
   // ----------------------------------------
   always_comb begin
      next_state = state;
      // Idle cycles load zeros so an address held by the requester is not routed twice
      if (req.valid) begin
         next_state.dec = pad_decode(req.addr);
      end else begin
         next_state.dec = PAD_DEC_RESET;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= '{dec: PAD_DEC_RESET};
      end else begin
         state <= next_state;
      end
   end

   assign dec = state.dec;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Field bounds and widths must agree, or the struct slices go wrong silently
   if (PAD_NODE_HI - PAD_NODE_LO + 1 != PAD_NODE_W) begin : g_bad_node_w
      $error("Node field width does not match its bounds");
   end
   if (PAD_MAX_PROC_NODES > 2 ** PAD_NODE_W) begin : g_bad_node_count
      $error("Node field too narrow for the node count");
   end
   if (PAD_NODE_HI != PAD_PHYS_W - 1) begin : g_bad_phys_w
      $error("Node field must end at the top physical bit");
   end
   if (PAD_TYPE_BIT != PAD_NODE_LO) begin : g_bad_type_bit
      $error("Node type must be the lowest node bit");
   end
   if (PAD_SEL_HI != PAD_NODE_LO - 1 || PAD_SEL_HI != PAD_SEL_LO + 1) begin : g_bad_sel
      $error("Space selector must be two bits below the node field");
   end
   if (PAD_OFS_W != PAD_SEL_LO || PAD_HALF_BIT != PAD_OFS_W - 1) begin : g_bad_ofs
      $error("Offset must fill the bits below the selector");
   end
   if (PAD_ADDR_W < PAD_PHYS_W) begin : g_bad_addr_w
      $error("Request address narrower than the physical address");
   end

   property p_valid_follows;
      @(posedge mclk) disable iff (rst) req.valid |=> dec.valid;
   endproperty
   a_valid_follows: assert property (p_valid_follows) else $error("Valid not registered");

   property p_node_id;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.node_id == $past(req.addr[49:38]);
   endproperty
   a_node_id: assert property (p_node_id) else $error("Node id wrong");

   property p_offset;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.offset == $past(req.addr[35:0]);
   endproperty
   a_offset: assert property (p_offset) else $error("Offset wrong");

   property p_proc_node;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.proc_node == !$past(req.addr[38]);
   endproperty
   a_proc_node: assert property (p_proc_node) else $error("Node type wrong");

   sequence s_local_req;
      req.valid && req.addr[37:35] == 3'h0;
   endsequence
   property p_local;
      @(posedge mclk) disable iff (rst)
         s_local_req |=> dec.local_space && !dec.mapped_register_space;
   endproperty
   a_local: assert property (p_local) else $error("Local space missed");

   sequence s_global_req;
      req.valid && req.addr[37:35] == 3'h1;
   endsequence
   property p_global;
      @(posedge mclk) disable iff (rst)
         s_global_req |=> dec.mapped_register_space && dec.pio_target && !dec.local_space;
   endproperty
   a_global: assert property (p_global) else $error("Global space missed");

   property p_mem;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.mem_req == ($past(req.addr[37:36]) == 2'h3);
   endproperty
   a_mem: assert property (p_mem) else $error("Memory request wrong");

   property p_space;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.atomic_op_space == ($past(req.addr[37:36]) == 2'h2)
            && dec.get_space == ($past(req.addr[37:36]) == 2'h1);
   endproperty
   a_space: assert property (p_space) else $error("Space select wrong");

   property p_reserved;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.reserved_err == ($past(req.addr[63:50]) != 14'h0);
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved flag wrong");

   property p_bit49;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.bit49_err == $past(req.addr[49]);
   endproperty
   a_bit49: assert property (p_bit49) else $error("Bit 49 flag wrong");

   property p_even;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.odd_hub_err == $past(req.addr[38]);
   endproperty
   a_even: assert property (p_even) else $error("Odd hub flag wrong");

   // ----------------------------------------
   // Reset and standing time
   // ----------------------------------------
   // No disable here: reset itself is what is watched
   property p_reset_clear;
      @(posedge mclk) rst |=> dec == PAD_DEC_RESET;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("Reset left output set");

   // Result stands one cycle, then drops to zero unless another request follows
   property p_idle_clear;
      @(posedge mclk) disable iff (rst) !req.valid |=> dec == PAD_DEC_RESET;
   endproperty
   a_idle_clear: assert property (p_idle_clear) else $error("Stale result");

   property p_no_ghost;
      @(posedge mclk) disable iff (rst) dec.valid |-> $past(req.valid) && !$past(rst);
   endproperty
   a_no_ghost: assert property (p_no_ghost) else $error("Result without request");

   // ----------------------------------------
   // Field placement
   // ----------------------------------------
   property p_selector;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.space_selector_bits == $past(req.addr[37:36]);
   endproperty
   a_selector: assert property (p_selector) else $error("Selector field wrong");

   // Node, selector and offset rebuild all fifty meaningful bits
   property p_region;
      @(posedge mclk) disable iff (rst)
         req.valid |=> {dec.node_id, dec.space_selector_bits, dec.offset} == $past(req.addr[49:0]);
   endproperty
   a_region: assert property (p_region) else $error("Hub region wrong");

   sequence s_even_node_req;
      req.valid && !req.addr[38];
   endsequence
   property p_even_proc;
      @(posedge mclk) disable iff (rst)
         s_even_node_req |=> dec.proc_node && !dec.odd_hub_err;
   endproperty
   a_even_proc: assert property (p_even_proc) else $error("Even node misread");

   // Bad addresses are flagged but still routed
   sequence s_reserved_req;
      req.valid && req.addr[63:50] != 14'h0;
   endsequence
   property p_reserved_routed;
      @(posedge mclk) disable iff (rst)
         s_reserved_req |=> dec.valid && dec.reserved_err
            && dec.offset == $past(req.addr[35:0]);
   endproperty
   a_reserved_routed: assert property (p_reserved_routed) else $error("Reserved blocked");

   // ----------------------------------------
   // Space routing
   // ----------------------------------------
   sequence s_zero_space_req;
      req.valid && req.addr[37:36] == 2'h0;
   endsequence
   property p_half_split;
      @(posedge mclk) disable iff (rst)
         s_zero_space_req |=> dec.local_space == !$past(req.addr[35])
            && dec.mapped_register_space == $past(req.addr[35]);
   endproperty
   a_half_split: assert property (p_half_split) else $error("Half select wrong");

   property p_pio;
      @(posedge mclk) disable iff (rst)
         req.valid |=> dec.pio_target == ($past(req.addr[37:35]) == 3'h1);
   endproperty
   a_pio: assert property (p_pio) else $error("I/O target wrong");

   // No requester field exists, so no node can be refused
   property p_global_any;
      @(posedge mclk) disable iff (rst)
         s_global_req |=> dec.node_id == $past(req.addr[49:38]) && !dec.mem_req;
   endproperty
   a_global_any: assert property (p_global_any) else $error("Global access refused");

   // Exactly one space flag per request
   property p_one_space;
      @(posedge mclk) disable iff (rst)
         req.valid |=> $onehot({dec.local_space, dec.mapped_register_space, dec.get_space,
            dec.atomic_op_space, dec.mem_req});
   endproperty
   a_one_space: assert property (p_one_space) else $error("Space flags not one-hot");

   sequence s_get_req;
      req.valid && req.addr[37:36] == 2'h1;
   endsequence
   property p_get;
      @(posedge mclk) disable iff (rst)
         s_get_req |=> dec.get_space && dec.space_selector_bits == PAD_SP_GET;
   endproperty
   a_get: assert property (p_get) else $error("Get space missed");

   sequence s_atomic_req;
      req.valid && req.addr[37:36] == 2'h2;
   endsequence
   property p_atomic;
      @(posedge mclk) disable iff (rst)
         s_atomic_req |=> dec.atomic_op_space && dec.space_selector_bits == PAD_SP_ATOMIC;
   endproperty
   a_atomic: assert property (p_atomic) else $error("Atomic space missed");

   sequence s_mem_space_req;
      req.valid && req.addr[37:36] == 2'h3;
   endsequence
   property p_cacheable_hub;
      @(posedge mclk) disable iff (rst)
         s_mem_space_req |=> dec.mem_req && dec.node_id == $past(req.addr[49:38]);
   endproperty
   a_cacheable_hub: assert property (p_cacheable_hub) else $error("Memory hub wrong");
endmodule

// ===== tb/pad_req_model.sv
// Requester model: presents processor addresses to the decoder.
`timescale 1ns/100ps
module pad_req_model (
   // Clock
   input wire logic mclk,
   // Command from bench
   input wire logic go,
   input wire logic clean,
   input wire logic [63:0] a,
   // Request to decoder
   output pad_pkg::pad_req_s req
);
   import pad_pkg::*;
   logic go_q;
   logic clean_q;
   logic [63:0] a_q;
   initial req = '0;
   // Command taken at the edge and applied a step later, so bench and model never race
   always @(posedge mclk) begin
      go_q = go;
      clean_q = clean;
      a_q = a;
      #1;
      req.valid <= go_q;
      // Idle address toggles so stale values never look valid
      if (!go_q) begin
         req.addr <= ~req.addr;
      end else if (clean_q) begin
         req.addr <= {15'h0000, a_q[48:39], 1'h0, a_q[37:0]};
      end else begin
         req.addr <= a_q;
      end
   end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the physical address decoder.
`timescale 1ns/100ps
module tb;
   import pad_pkg::*;
   logic mclk = 0, rst = 1, go = 0, clean = 1;
   logic [63:0] a = '0;
   pad_req_s req;
   pad_dec_s dec, e;
   int fail_count = 0, checked = 0;
   initial forever #12.5 mclk = ~mclk;
   pad_req_model req_model (.mclk(mclk), .go(go), .clean(clean), .a(a), .req(req));
   pad_decoder dut (.mclk(mclk), .rst(rst), .req(req), .dec(dec));

   function automatic pad_dec_s exp_f(logic v, logic [63:0] x);
      pad_dec_s d;
      d = '0;
      if (v === 1'h1) begin
         d.valid = 1'h1;
         d.node_id = x[49:38];
         d.proc_node = ~x[38];
         d.space_selector_bits = pad_space_e'(x[37:36]);
         d.local_space = x[37:35] == 3'h0;
         d.mapped_register_space = x[37:35] == 3'h1;
         d.pio_target = x[37:35] == 3'h1;
         d.get_space = x[37:36] == 2'h1;
         d.atomic_op_space = x[37:36] == 2'h2;
         d.mem_req = x[37:36] == 2'h3;
         d.offset = x[35:0];
         d.reserved_err = |x[63:50];
         d.bit49_err = x[49];
         d.odd_hub_err = x[38];
      end
      return d;
   endfunction

   task automatic wrap_up();
      $display("checks %0d errors %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Expectation taken from the request seen at the same edge
   always @(posedge mclk) begin
      e = exp_f(req.valid & ~rst, req.addr);
      #2;
      if ($time > 100) begin
         checked++;
         if (dec !== e) begin
            fail_count++;
            $display("Error dec expected %h seen %h", e, dec);
         end
      end
   end

   initial begin
      #20000;
      fail_count++;
      wrap_up();
   end

   initial begin
      void'($urandom(27));
      repeat (20) @(posedge mclk);
      #1 rst = 0;
      // Every selector and half, back to back, top node and full offset
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         #1 go = 1;
         a = {15'h0000, 10'h3FF, 1'h0, 3'(i), 35'h7_FFFF_FFFF};
      end
      // Flagged addresses are still routed: reserved bits, bit 49, odd node
      @(posedge mclk);
      #1 clean = 0;
      a = 64'hFFFF_FFFF_FFFF_FFFF;
      @(posedge mclk);
      #1 a = 64'h0002_0000_0000_0000;
      @(posedge mclk);
      #1 a = 64'h0000_0040_0000_0000;
      repeat (300) begin
         @(posedge mclk);
         #1 go = 1'($urandom_range(0, 1));
         clean = 1'($urandom_range(0, 1));
         a = {$urandom, $urandom};
      end
      // Reset in mid-stream while requests keep coming
      @(posedge mclk);
      #1 rst = 1;
      go = 1;
      repeat (2) @(posedge mclk);
      #1 rst = 0;
      repeat (6) begin
         @(posedge mclk);
         #1 a = {$urandom, $urandom};
      end
      @(posedge mclk);
      #1 go = 0;
      repeat (3) @(posedge mclk);
      wrap_up();
   end
endmodule
